// file: core/interp_stage.sv
// One zero-stuffing 2x interpolation stage with a symmetric coefficient set.
// Assumes tick comes every output slot and load on every other tick.
`timescale 1ns/1ps
module interp_stage #(
	parameter tx_interp_pkg::stage_kind_t KIND = tx_interp_pkg::KIND_HB1
) (
	// Clock and reset
	input wire logic   clk_sys_in,
	input wire logic   rst_in,
	// Stage link
	stage_link_if.stage link
);

	localparam int                  TAPS  = tx_interp_pkg::taps_of(KIND);
	localparam int                  SHIFT = tx_interp_pkg::shift_of(KIND);
	localparam tx_interp_pkg::acc_t ROUND = tx_interp_pkg::acc_t'(1) <<< (SHIFT - 1);

	tx_interp_pkg::sample_t line_reg [0:TAPS-1]; // Zero-stuffed delay line.
	tx_interp_pkg::acc_t    acc;                 // Rounded sum of products.
	tx_interp_pkg::sample_t dout_reg;            // Saturated output.

	// ==========================================================================
	// Delay line
	// ==========================================================================
	// A zero is pushed between samples, which doubles the rate.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			for (int k = 0; k < TAPS; k++) begin
				line_reg[k] <= '0;
			end
		end else if (link.tick) begin
			line_reg[0] <= link.load ? link.din : '0;
			for (int k = 1; k < TAPS; k++) begin
				line_reg[k] <= line_reg[k-1];
			end
		end
	end

	// ==========================================================================
	// Multiply and accumulate
	// ==========================================================================
	// Constant zero taps drop out in synthesis, so the half-band cost is halved.
	always_comb begin
		acc = ROUND;
		for (int k = 0; k < TAPS; k++) begin
			// Both factors are widened first so the product cannot wrap at the coefficient width.
			acc = acc + tx_interp_pkg::acc_t'(tx_interp_pkg::coef_of(KIND, k))
				* tx_interp_pkg::acc_t'(line_reg[k]);
		end
	end

	// Shift by the centre weight, round and clamp; the output holds between ticks.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			dout_reg <= '0;
		end else if (link.tick) begin
			dout_reg <= tx_interp_pkg::saturate(acc >>> SHIFT);
		end
	end

	assign link.dout = dout_reg;

	// ==========================================================================
	// Checks
	// ==========================================================================
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	a_zero_stuff: assert property (link.tick && !link.load |=> line_reg[0] == '0)
		else $error("Stuffed slot did not insert a zero.");
	a_load_sample: assert property (link.tick && link.load |=> line_reg[0] == $past(link.din))
		else $error("Loaded sample missing from the delay line.");
	a_hold_out: assert property (!link.tick |=> $stable(dout_reg))
		else $error("Stage output moved without a tick.");

endmodule : interp_stage

// file: core/stage_link_if.sv
// Link between the chain control and one 2x interpolation stage.
// Assumes the feeding side drives tick, load and din on the converter sample clock.
`timescale 1ns/1ps
interface stage_link_if;
	logic                  tick; // Output-rate strobe of the stage.
	logic                  load; // High on ticks that carry a new input sample.
	tx_interp_pkg::sample_t din;  // Input sample.
	tx_interp_pkg::sample_t dout; // Registered filter output.
	modport feed  (output tick, output load, output din, input dout);
	modport stage (input tick, input load, input din, output dout);
endinterface : stage_link_if

// file: core/tx_interp_pkg.sv
// Constants, types and coefficient tables for the transmit interpolation chain.
// Assumes every user runs on the converter sample clock and names items as tx_interp_pkg::name.
package tx_interp_pkg;

	// ==========================================================================
	// Widths and sizes
	// ==========================================================================
	localparam int SAMPLE_W   = 12; // Converter word width.
	localparam int COEF_W     = 16; // Coefficient width.
	localparam int ACC_W      = 36; // Accumulator width, wide enough for 53 taps.
	localparam int FIFO_DEPTH = 8;  // Transmit buffer entries.
	localparam int PTR_W      = 3;  // Buffer pointer width.
	localparam int CNT_W      = 4;  // Buffer fill count width.
	localparam int PHASE_W    = 3;  // Read divider phase width.
	localparam int HB1_TAPS   = 43;
	localparam int HB2_TAPS   = 19;
	localparam int RRC_TAPS   = 53;
	localparam int HB1_SHIFT  = 14; // Normalisation shift, log2 of the centre weight.
	localparam int HB2_SHIFT  = 13;
	localparam int RRC_SHIFT  = 14;

	typedef logic signed [SAMPLE_W-1:0] sample_t;
	typedef logic signed [COEF_W-1:0]   coef_t;
	typedef logic signed [ACC_W-1:0]    acc_t;

	localparam sample_t SAMPLE_MAX = 12'sh7FF;
	localparam sample_t SAMPLE_MIN = -12'sh800;

	// Overall interpolation ratio; the code is also the number of active stages.
	typedef enum logic [1:0] {
		RATIO_1 = 2'b00,
		RATIO_2 = 2'b01,
		RATIO_4 = 2'b10,
		RATIO_8 = 2'b11
	} ratio_t;

	typedef enum logic [1:0] {
		KIND_HB1 = 2'b00,
		KIND_HB2 = 2'b01,
		KIND_RRC = 2'b10
	} stage_kind_t;

	// ==========================================================================
	// Coefficients, lower half up to and including the centre tap
	// ==========================================================================
	// Half-band tables hold zeros on the odd taps below the centre so the multipliers vanish.
	localparam coef_t HB1_LOW [0:21] = '{
		16'sh000C, 16'sh0, -16'sh0020, 16'sh0, 16'sh0048, 16'sh0, -16'sh008C, 16'sh0,
		16'sh00FC, 16'sh0, -16'sh01A6, 16'sh0, 16'sh02AA, 16'sh0, -16'sh043E, 16'sh0,
		16'sh06F2, 16'sh0, -16'sh0CD4, 16'sh0, 16'sh287C, 16'sh4000};
	localparam coef_t HB2_LOW [0:9] = '{
		16'sh001A, 16'sh0, -16'sh008A, 16'sh0, 16'sh01D2, 16'sh0, -16'sh0522, 16'sh0,
		16'sh13C2, 16'sh1FFF};
	// Roll-off 0.22 shaping with every tap in use.
	localparam coef_t RRC_LOW [0:26] = '{
		-16'sh0002, -16'sh0002, 16'sh0008, -16'sh0004, -16'sh0015, 16'sh000A, 16'sh002C,
		-16'sh001D, -16'sh004F, 16'sh0042, 16'sh007B, -16'sh007F, -16'sh00B7, 16'sh00E8,
		16'sh00FB, -16'sh018A, -16'sh0146, 16'sh0282, 16'sh0191, -16'sh040A, -16'sh01D5,
		16'sh06A8, 16'sh020B, -16'sh0C58, -16'sh0230, 16'sh270C, 16'sh3FFF};

	// ==========================================================================
	// Decoding functions
	// ==========================================================================
	function automatic int taps_of(stage_kind_t kind);
		case (kind)
			KIND_HB2: taps_of = HB2_TAPS;
			KIND_RRC: taps_of = RRC_TAPS;
			default:  taps_of = HB1_TAPS;
		endcase
	endfunction : taps_of

	function automatic int shift_of(stage_kind_t kind);
		case (kind)
			KIND_HB2: shift_of = HB2_SHIFT;
			KIND_RRC: shift_of = RRC_SHIFT;
			default:  shift_of = HB1_SHIFT;
		endcase
	endfunction : shift_of

	// Mirrors the stored lower half so the full symmetric set is produced.
	function automatic coef_t coef_of(stage_kind_t kind, int k);
		int n;
		int c;
		int m;
		n = taps_of(kind);
		c = (n - 1) / 2;
		m = (k > c) ? (n - 1 - k) : k;
		case (kind)
			KIND_HB1: coef_of = HB1_LOW[m];
			KIND_HB2: coef_of = HB2_LOW[m];
			KIND_RRC: coef_of = RRC_LOW[m];
			default:  coef_of = 16'sh0;
		endcase
	endfunction : coef_of

	// Divider mask: the read phase wraps at the ratio.
	function automatic logic [PHASE_W-1:0] ratio_mask(ratio_t r);
		case (r)
			RATIO_1: ratio_mask = 3'h0;
			RATIO_2: ratio_mask = 3'h1;
			RATIO_4: ratio_mask = 3'h3;
			default: ratio_mask = 3'h7;
		endcase
	endfunction : ratio_mask

	// Output tick of cascade level 1..3 for the given ratio and phase.
	function automatic logic tick_of(ratio_t r, logic [PHASE_W-1:0] phase, int level);
		tick_of = (int'(r) >= level) && ((phase & (ratio_mask(r) >> level)) == 3'h0);
	endfunction : tick_of

	// Clamps a normalised sum to the converter range.
	function automatic sample_t saturate(acc_t v);
		if (v > acc_t'(SAMPLE_MAX)) begin
			saturate = SAMPLE_MAX;
		end else if (v < acc_t'(SAMPLE_MIN)) begin
			saturate = SAMPLE_MIN;
		end else begin
			saturate = v[SAMPLE_W-1:0];
		end
	endfunction : saturate

endpackage : tx_interp_pkg

// file: core/tx_interpolation_filter_chain.sv
// Transmit interpolation chain: input latch, I/Q assembler, buffer and three 2x stages per channel.
// Assumes clk_sys_in is the converter sample clock and host words are synchronous to it.
//
// Function
// - Three 2x stages per I and Q channel.
// - All stages bypassable for ratio one.
// - Ratio selects first, first two, or all stages.
// - Half-band even taps zero except centre.
// - First half-band: 43 taps, published values.
// - Second half-band: 19 taps, published values.
// - Root-raised-cosine: 53 taps, published values.
// - Select port, split interleaved I/Q, buffer.
// - Chain output drives each channel's converter.
// - Half-band band 40%, ripple below 0.1 dB.
// - Roll-off 0.22, 60 dB stop band.
// - Image rejection 70 dB, 65 dB at 8x.
// - Eight-entry buffer absorbs clock phase drift.
// - Buffer read at converter clock over ratio.
// - Buffer writes at half the bus rate.
// - Doubler only at ratio one, bus rate.
`timescale 1ns/1ps
module tx_interpolation_filter_chain (
	// Clock and reset
	input  wire logic                    clk_sys_in,
	input  wire logic                    rst_in,
	// Host data port A
	input  wire tx_interp_pkg::sample_t  port_a_data_in,
	input  wire logic                    port_a_iq_in,
	input  wire logic                    port_a_valid_in,
	// Host data port B
	input  wire tx_interp_pkg::sample_t  port_b_data_in,
	input  wire logic                    port_b_iq_in,
	input  wire logic                    port_b_valid_in,
	// Mode selection
	input  wire logic                    port_sel_in,
	input  wire tx_interp_pkg::ratio_t   interp_ratio_in,
	input  wire logic                    tx_bus_rate_mode_in,
	// Converter samples
	output tx_interp_pkg::sample_t       dac_i_out,
	output tx_interp_pkg::sample_t       dac_q_out,
	// Status
	output logic                         buffer_read_clock_out,
	output logic                         buffer_write_clock_out,
	output logic                         clock_doubler_out,
	output logic                         fifo_overflow_out,
	output logic                         fifo_underflow_out
);

	// ==========================================================================
	// Declarations
	// ==========================================================================
	tx_interp_pkg::sample_t lat_data_reg;   // Latched host word.
	logic                   lat_iq_reg;     // Latched I/Q marker, high for I.
	logic                   lat_valid_reg;  // Latched word strobe.
	tx_interp_pkg::sample_t hold_i_reg;     // I half waiting for its Q.
	logic                   have_i_reg;     // An I word is waiting.
	logic                   pair_ready;     // A full I/Q pair is present.
	tx_interp_pkg::sample_t fifo_i_mem [0:tx_interp_pkg::FIFO_DEPTH-1];
	tx_interp_pkg::sample_t fifo_q_mem [0:tx_interp_pkg::FIFO_DEPTH-1];
	logic [tx_interp_pkg::PTR_W-1:0]   wr_ptr_reg;  // Next entry to write.
	logic [tx_interp_pkg::PTR_W-1:0]   rd_ptr_reg;  // Oldest entry.
	logic [tx_interp_pkg::CNT_W-1:0]   count_reg;   // Entries held.
	logic                   full;           // Buffer holds eight pairs.
	logic                   empty;          // Buffer holds nothing.
	logic                   push;           // Write one pair.
	logic                   pop;            // Read one pair.
	tx_interp_pkg::ratio_t  ratio_reg;      // Active ratio.
	logic [tx_interp_pkg::PHASE_W-1:0] phase_reg;   // Read divider phase.
	logic                   rd_stb;         // Buffer read slot.
	logic [3:1]             tick;           // Output ticks of the three levels.
	tx_interp_pkg::sample_t samp_reg [0:1]; // Last sample read, per channel.
	tx_interp_pkg::sample_t chain_out [0:1];// Selected chain output.
	tx_interp_pkg::sample_t dac_reg [0:1];  // Converter words.
	logic                   rd_out_reg;
	logic                   wr_out_reg;
	logic                   doubler_reg;
	logic                   ovf_reg;
	logic                   unf_reg;

	// ==========================================================================
	// Input latch and assembler
	// ==========================================================================
	// The selected port is registered first so the assembler sees clean words.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			lat_data_reg  <= '0;
			lat_iq_reg    <= 1'b0;
			lat_valid_reg <= 1'b0;
		end else if (port_sel_in) begin
			lat_data_reg  <= port_b_data_in;
			lat_iq_reg    <= port_b_iq_in;
			lat_valid_reg <= port_b_valid_in;
		end else begin
			lat_data_reg  <= port_a_data_in;
			lat_iq_reg    <= port_a_iq_in;
			lat_valid_reg <= port_a_valid_in;
		end
	end

	// An I word is parked; the following Q word completes the pair.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			hold_i_reg <= '0;
			have_i_reg <= 1'b0;
		end else if (lat_valid_reg && lat_iq_reg) begin
			hold_i_reg <= lat_data_reg;
			have_i_reg <= 1'b1;
		end else if (lat_valid_reg) begin
			have_i_reg <= 1'b0; // A Q word without an I is dropped.
		end
	end

	// One write per pair, so writes run at half the bus word rate.
	assign pair_ready = lat_valid_reg && !lat_iq_reg && have_i_reg;

	// ==========================================================================
	// Transmit buffer
	// ==========================================================================
	// Eight entries give slack between host pacing and the read divider.
	assign full  = count_reg == tx_interp_pkg::CNT_W'(tx_interp_pkg::FIFO_DEPTH);
	assign empty = count_reg == '0;
	assign push  = pair_ready && !full;
	assign pop   = rd_stb && !empty;

	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			fifo_i_mem[wr_ptr_reg] <= hold_i_reg;
			fifo_q_mem[wr_ptr_reg] <= lat_data_reg;
		end
	end

	// Pointers wrap naturally at eight; the count tracks fill level.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	// ==========================================================================
	// Ratio and read divider
	// ==========================================================================
	// The phase restarts whenever the ratio changes so all stages realign.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ratio_reg <= tx_interp_pkg::RATIO_1;
			phase_reg <= '0;
		end else if (interp_ratio_in != ratio_reg) begin
			ratio_reg <= interp_ratio_in;
			phase_reg <= '0;
		end else begin
			phase_reg <= (phase_reg + 1'b1) & tx_interp_pkg::ratio_mask(ratio_reg);
		end
	end

	// The read slot is the converter clock divided by the ratio.
	assign rd_stb = phase_reg == '0;

	// Only the stages that the ratio needs receive ticks; the rest stay idle.
	genvar lv;
	generate
		for (lv = 1; lv <= 3; lv++) begin : g_tick
			assign tick[lv] = tx_interp_pkg::tick_of(ratio_reg, phase_reg, lv);
		end
	endgenerate

	// ==========================================================================
	// Channels
	// ==========================================================================
	// Each channel holds its last sample so an empty buffer repeats rather than glitches.
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			stage_link_if hb1_link ();
			stage_link_if hb2_link ();
			stage_link_if rrc_link ();

			always_ff @(posedge clk_sys_in) begin
				if (rst_in) begin
					samp_reg[ch] <= '0;
				end else if (pop) begin
					samp_reg[ch] <= (ch == 0) ? fifo_i_mem[rd_ptr_reg] : fifo_q_mem[rd_ptr_reg];
				end
			end

			// Cascade: each stage after the first loads on the ticks of the stage before it; the first loads on the read slot.
			assign hb1_link.tick = tick[1];
			assign hb1_link.load = rd_stb;
			assign hb1_link.din  = samp_reg[ch];
			assign hb2_link.tick = tick[2];
			assign hb2_link.load = tick[1];
			assign hb2_link.din  = hb1_link.dout;
			assign rrc_link.tick = tick[3];
			assign rrc_link.load = tick[2];
			assign rrc_link.din  = hb2_link.dout;

			interp_stage #(.KIND(tx_interp_pkg::KIND_HB1)) u_first_halfband_stage (
				.clk_sys_in (clk_sys_in),
				.rst_in     (rst_in),
				.link       (hb1_link)
			);
			interp_stage #(.KIND(tx_interp_pkg::KIND_HB2)) u_second_halfband_stage (
				.clk_sys_in (clk_sys_in),
				.rst_in     (rst_in),
				.link       (hb2_link)
			);
			interp_stage #(.KIND(tx_interp_pkg::KIND_RRC)) u_root_raised_cosine_stage (
				.clk_sys_in (clk_sys_in),
				.rst_in     (rst_in),
				.link       (rrc_link)
			);

			// Ratio one takes the buffered sample straight through.
			always_comb begin
				case (ratio_reg)
					tx_interp_pkg::RATIO_1: chain_out[ch] = samp_reg[ch];
					tx_interp_pkg::RATIO_2: chain_out[ch] = hb1_link.dout;
					tx_interp_pkg::RATIO_4: chain_out[ch] = hb2_link.dout;
					default:                chain_out[ch] = rrc_link.dout;
				endcase
			end

			// One converter word per clock.
			always_ff @(posedge clk_sys_in) begin
				if (rst_in) begin
					dac_reg[ch] <= '0;
				end else begin
					dac_reg[ch] <= chain_out[ch];
				end
			end
		end
	endgenerate

	// ==========================================================================
	// Status flags
	// ==========================================================================
	// Each flag except the doubler level is high one cycle per event, so read stays high at ratio one; an overflow loses the incoming pair.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rd_out_reg  <= 1'b0;
			wr_out_reg  <= 1'b0;
			doubler_reg <= 1'b0;
			ovf_reg     <= 1'b0;
			unf_reg     <= 1'b0;
		end else begin
			rd_out_reg  <= rd_stb;
			wr_out_reg  <= push;
			doubler_reg <= (ratio_reg == tx_interp_pkg::RATIO_1) && tx_bus_rate_mode_in;
			ovf_reg     <= pair_ready && full;
			unf_reg     <= rd_stb && empty;
		end
	end

	assign dac_i_out              = dac_reg[0];
	assign dac_q_out              = dac_reg[1];
	assign buffer_read_clock_out  = rd_out_reg;
	assign buffer_write_clock_out = wr_out_reg;
	assign clock_doubler_out      = doubler_reg;
	assign fifo_overflow_out      = ovf_reg;
	assign fifo_underflow_out     = unf_reg;

	// ==========================================================================
	// Checks
	// ==========================================================================
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	a_read_gap8: assert property (rd_stb && ratio_reg == tx_interp_pkg::RATIO_8 &&
		interp_ratio_in == tx_interp_pkg::RATIO_8 |=> (!rd_stb)[*7] ##1 rd_stb)
		else $error("Read slot spacing wrong at ratio eight.");
	a_fifo_bound: assert property (count_reg <= tx_interp_pkg::CNT_W'(tx_interp_pkg::FIFO_DEPTH))
		else $error("Buffer count exceeds eight.");
	a_push_count: assert property (push && !pop |=> count_reg == $past(count_reg) + 1'b1)
		else $error("Pair write did not raise the count.");
	a_overflow_flag: assert property (pair_ready && full |=> fifo_overflow_out && $stable(wr_ptr_reg))
		else $error("Overflow not flagged or pair written.");
	a_bypass_path: assert property (ratio_reg == tx_interp_pkg::RATIO_1 |=> dac_i_out == $past(samp_reg[0]))
		else $error("Bypass did not pass the sample through.");
	a_doubler_flag: assert property ((ratio_reg == tx_interp_pkg::RATIO_1) && tx_bus_rate_mode_in
		|=> clock_doubler_out)
		else $error("Doubler not reported at ratio one in bus rate mode.");
	a_no_doubler: assert property (ratio_reg != tx_interp_pkg::RATIO_1 |=> !clock_doubler_out)
		else $error("Doubler reported with stages enabled.");
	a_tick_cascade: assert property (ratio_reg == tx_interp_pkg::RATIO_8 |-> tick[3] &&
		(!tick[1] || tick[2]) && (!rd_stb || tick[1]))
		else $error("Stage ticks out of step at ratio eight.");
	a_idle_stages: assert property (ratio_reg == tx_interp_pkg::RATIO_2 |-> tick[1] && !tick[2] && !tick[3])
		else $error("Wrong stages active at ratio two.");

	c_ratio8_read: cover property (rd_stb && ratio_reg == tx_interp_pkg::RATIO_8 && !empty);
	c_fifo_full: cover property (full);
	c_overflow: cover property (pair_ready && full);
	c_bypass_bus: cover property (ratio_reg == tx_interp_pkg::RATIO_1 && tx_bus_rate_mode_in && pop);

endmodule : tx_interpolation_filter_chain

// file: verification/iq_host_model.sv
// Behavioural baseband host model that drives interleaved I/Q words on port A or B.
// Assumes the bench calls its tasks just after a rising clock edge, one word per cycle.
`timescale 1ns/1ps
module iq_host_model (
	// Clock
	input  wire logic              clk_sys_in,
	// Host port A
	output tx_interp_pkg::sample_t a_data_out,
	output logic                   a_iq_out,
	output logic                   a_valid_out,
	// Host port B
	output tx_interp_pkg::sample_t b_data_out,
	output logic                   b_iq_out,
	output logic                   b_valid_out
);
	// ==========================================================================
	// Word driver
	// ==========================================================================
	// Both ports start idle.
	initial begin
		{a_data_out, a_iq_out, a_valid_out} = '0;
		{b_data_out, b_iq_out, b_valid_out} = '0;
	end
	// Holds one word for one cycle; the other port shows flipped data so no stale word looks real.
	task automatic send_word(input logic port, input logic iq, input tx_interp_pkg::sample_t d);
		{a_data_out, a_iq_out, a_valid_out} = port ? {~a_data_out, 1'b0, 1'b0} : {d, iq, 1'b1};
		{b_data_out, b_iq_out, b_valid_out} = port ? {d, iq, 1'b1} : {~b_data_out, 1'b0, 1'b0};
		@(posedge clk_sys_in);
		#1;
	endtask : send_word
	// Releases both ports; the data is inverted because nobody holds it any more.
	task automatic idle();
		{a_data_out, a_valid_out} = {~a_data_out, 1'b0};
		{b_data_out, b_valid_out} = {~b_data_out, 1'b0};
	endtask : idle
endmodule : iq_host_model

// file: verification/tb_top.sv
// Self-checking bench for the transmit interpolation chain.
// Assumes the host model drives the ports and that bypass shows popped pairs two edges after the read slot.
`timescale 1ns/1ps
module tb_top;
	logic                   clk_sys_in, rst_in, sel, sdr, rd, wr, dbl, ovf, und, chk_en, pend;
	logic                   a_iq, a_v, b_iq, b_v;
	tx_interp_pkg::sample_t a_d, b_d, dac_i, dac_q;
	tx_interp_pkg::ratio_t  ratio;
	int                     n_fail, n_checks, n_rd, n_wr, n_ovf, n_und, cyc, dc, k;
	int                     q_i[$], q_q[$];
	logic [31:0]            lfsr;
	tx_interpolation_filter_chain u_tx_interpolation_filter_chain (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.port_a_data_in(a_d), .port_a_iq_in(a_iq), .port_a_valid_in(a_v), .port_b_data_in(b_d),
		.port_b_iq_in(b_iq), .port_b_valid_in(b_v), .port_sel_in(sel), .interp_ratio_in(ratio),
		.tx_bus_rate_mode_in(sdr), .dac_i_out(dac_i), .dac_q_out(dac_q), .buffer_read_clock_out(rd),
		.buffer_write_clock_out(wr), .clock_doubler_out(dbl), .fifo_overflow_out(ovf), .fifo_underflow_out(und));
	iq_host_model u_iq_host_model (.clk_sys_in(clk_sys_in), .a_data_out(a_d), .a_iq_out(a_iq),
		.a_valid_out(a_v), .b_data_out(b_d), .b_iq_out(b_iq), .b_valid_out(b_v));
	// ==========================================================================
	// Compare tasks and verdict
	// ==========================================================================
	// Sample compare with a tolerance, since filtered levels round in the last bit.
	task automatic cmp(input string nm, input int e, input tx_interp_pkg::sample_t g, input int tol);
		n_checks++;
		if ($isunknown(g) || int'(g) - e > tol || e - int'(g) > tol) begin
			n_fail++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask : cmp
	// Status flag compare.
	task automatic cmp_flag(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_flag
	// Count compare against a range.
	task automatic cmp_cnt(input string nm, input int lo, input int hi, input int g);
		n_checks++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : cmp_cnt
	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	// Feedback register for random words.
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	// Sends one I word then its Q word back to back.
	task automatic send_pair(input int i, input int q);
		u_iq_host_model.send_word(sel, 1'b1, tx_interp_pkg::sample_t'(i));
		u_iq_host_model.send_word(sel, 1'b0, tx_interp_pkg::sample_t'(q));
	endtask : send_pair
	// ==========================================================================
	// Clock, monitor and timeout
	// ==========================================================================
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	// Counts strobes and, in bypass, checks each popped pair against the queue one cycle after its read pulse.
	always @(posedge clk_sys_in) begin
		cyc++;
		n_rd += int'(rd);
		n_wr += int'(wr);
		n_ovf += int'(ovf);
		n_und += int'(und);
		if (pend) begin
			cmp("dac_i", q_i.pop_front(), dac_i, 0);
			cmp("dac_q", q_q.pop_front(), dac_q, 0);
		end
		pend <= chk_en && rd && !und && q_i.size() > 0;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	// ==========================================================================
	// Scenarios
	// ==========================================================================
	initial begin
		{rst_in, sel, sdr, chk_en, pend} = 5'h10;
		ratio = tx_interp_pkg::RATIO_1;
		lfsr = 32'h3C5B;
		repeat (4) @(posedge clk_sys_in);
		#1 rst_in = 1'b0;
		// Doubler only in bypass with bus rate mode.
		sdr = 1'b1;
		repeat (3) @(posedge clk_sys_in);
		cmp_flag("doubler", 1'b1, dbl);
		#1 ratio = tx_interp_pkg::RATIO_2;
		repeat (3) @(posedge clk_sys_in);
		cmp_flag("doubler", 1'b0, dbl);
		#1 {chk_en, n_wr} = {1'b1, 32'h0};
		ratio = tx_interp_pkg::RATIO_1; // Bus rate mode stays high so bypass pops run with the doubler on.
		// Random pairs in bypass on alternating ports, with a lone Q and an overwritten I mixed in.
		for (k = 0; k < 16; k++) begin
			sel = k[0];
			lfsr = lfsr_next(lfsr);
			if (k == 8) u_iq_host_model.send_word(sel, 1'b0, 12'h5A5);
			if (k == 9) u_iq_host_model.send_word(sel, 1'b1, 12'h3C3);
			q_i.push_back(int'(tx_interp_pkg::sample_t'(lfsr[11:0])));
			q_q.push_back(int'(tx_interp_pkg::sample_t'(lfsr[27:16])));
			send_pair(q_i[$], q_q[$]);
		end
		u_iq_host_model.idle();
		repeat (10) @(posedge clk_sys_in);
		cmp_cnt("writes", 16, 16, n_wr);
		cmp_cnt("left", 0, 0, q_i.size());
		// Steady level through every ratio: read rate and settled level, plus overflow and underflow at ratios one and eight.
		for (k = 0; k < 4; k++) begin
			#1 ratio = tx_interp_pkg::ratio_t'(k);
			{chk_en, sdr} = {1'b0, k[0]};
			dc = 300 * (k + 1);
			n_ovf = 0;
			n_und = 0;
			for (int p = 0; p < 132; p++) begin
				if (p == 100) n_rd = 0;
				send_pair(dc, -dc);
			end
			cmp_cnt("reads", (64 >> k) - 1, (64 >> k) + 1, n_rd);
			cmp("level_i", dc, dac_i, k == 3 ? dc / 8 : 2);
			cmp("level_q", -dc, dac_q, k == 3 ? dc / 8 : 2);
			cmp_flag("doubler", 1'b0, dbl);
			if (k == 0 || k == 3) cmp_cnt("overflow", k == 3, k == 3 ? 1000 : 0, n_ovf);
			if (k == 0 || k == 3) cmp_cnt("underflow", k == 0, k == 0 ? 1000 : 0, n_und);
		end
		u_iq_host_model.idle();
		results();
	end
endmodule : tb_top
